// ### common/upm_pkg.sv
// constants and types shared by the parity, mute and sync clock logic
`default_nettype none
package upm_pkg;
    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int DATA_W = 9;                  // longest data field
    localparam int NODE_W = 4;                  // node address width
    localparam int DIV_W = 16;                  // bit period divider width
    localparam int BIT_W = 4;                   // bit index width
    // -----------------------------------------------------------------
    // frame lengths
    // -----------------------------------------------------------------
    localparam logic [3:0] BITS_SHORT = 4'h8;   // length select 0
    localparam logic [3:0] BITS_LONG = 4'h9;    // length select 1
    localparam logic [3:0] FRAME_EXTRA = 4'h2;  // start plus stop bit
    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic LINE_IDLE = 1'b1;          // line level at rest
    localparam logic MUTE_RST = 1'b0;           // receiver awake
    localparam logic [8:0] DATA_RST = 9'h000;   // empty receive word
    localparam logic [15:0] CNT_RST = 16'h0000; // counter start
    // -----------------------------------------------------------------
    // state types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} upm_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} upm_rx_state_type;
endpackage
`default_nettype wire

// ### common/upm_par_if.sv
// parity request and answer between the top and the parity unit
`timescale 1ns/1ps
`default_nettype none
interface upm_par_if;
    logic [8:0] data; // data word, low bits used
    logic nine_bit;   // 1: eight bits covered, 0: seven
    logic odd;        // 1: odd parity, 0: even
    logic par;        // computed parity bit
    modport calc (input data, input nine_bit, input odd, output par);
    modport user (output data, output nine_bit, output odd, input par);
endinterface
`default_nettype wire

// ### hw/upm_parity.sv
// parity bit calculation over seven or eight low data bits
`timescale 1ns/1ps
`default_nettype none
module upm_parity
(
    upm_par_if.calc p // parity request and answer
);
    // -----------------------------------------------------------------
    // parity
    // -----------------------------------------------------------------
    // even: xor of covered bits, odd: its inverse
    always_comb
    begin
        p.par = p.odd ^ (^p.data[6:0]) ^ (p.nine_bit & p.data[7]);
    end
endmodule // upm_parity
`default_nettype wire

// ### hw/upm_top.sv
// parity, mute wakeup and synchronous master clock of a serial transceiver
`timescale 1ns/1ps
`default_nettype none
module upm_top
(
    input wire logic clk_sys,             // system clock
    input wire logic sys_rst,             // async reset, active high
    input wire logic transmitter_enable,  // transmitter on
    input wire logic receiver_enable,     // receiver on
    input wire logic sync_clock_enable,   // synchronous master clock on
    input wire logic lin_enable,          // lin mode, blocks sync clock
    input wire logic [15:0] baud_div,     // clocks per bit, at least 16
    input wire logic length_select,       // 0: 8 bits, 1: 9 bits
    input wire logic parity_enable,       // parity on
    input wire logic parity_select,       // 0 even, 1 odd
    input wire logic parity_irq_enable,   // parity interrupt enable
    input wire logic parity_clear,        // pulse clears parity flag
    input wire logic wake_select,         // 0 idle line, 1 address mark
    input wire logic [3:0] node_address,  // own node address
    input wire logic mute_write,          // pulse: write mute bit
    input wire logic mute_write_value,    // value written to mute bit
    input wire logic last_bit_clock,      // pulse on last data bit
    input wire logic clock_polarity,      // clock idle level
    input wire logic clock_phase,         // data edge select
    input wire logic [8:0] tx_data,       // word to send
    input wire logic tx_valid,            // word offered
    output logic tx_ready,                // word taken when valid
    input wire logic rx_read,             // pulse: buffer read
    output logic [8:0] rx_data,           // received word
    output logic rx_not_empty,            // receive buffer full
    output logic parity_error_flag,       // sticky parity failure
    output logic parity_irq,              // parity interrupt request
    output logic receiver_mute,           // mute state
    input wire logic rx_pin,              // serial receive pin
    output logic tx_pin_out,              // serial transmit level
    output logic tx_pin_oe_n,             // low while tx driven
    output logic sync_clock_pin_out,      // clock pin level
    output logic sync_clock_pin_oe_n      // low while clock driven
);
    // -----------------------------------------------------------------
    // common frame figures
    // -----------------------------------------------------------------
    logic [3:0] nbits;        // data bits per frame
    logic [3:0] last_idx;     // index of last data bit
    logic [3:0] mark_idx;     // index of address mark
    logic [15:0] half_point;  // middle of a bit period
    logic [15:0] end_point;   // last count of a bit period
    logic sync_mode;          // synchronous master active
    logic any_en;             // transmitter or receiver on
    assign nbits = length_select ? upm_pkg::BITS_LONG : upm_pkg::BITS_SHORT;
    assign last_idx = nbits - 4'h1;
    // mark moves down one place when parity holds the top bit
    assign mark_idx = last_idx - {3'h0, parity_enable};
    assign half_point = {1'b0, baud_div[15:1]};
    assign end_point = baud_div - 16'h0001;
    // lin mode keeps the clock pin silent
    assign sync_mode = sync_clock_enable & ~lin_enable;
    assign any_en = transmitter_enable | receiver_enable;

    // -----------------------------------------------------------------
    // receive pin synchroniser
    // -----------------------------------------------------------------
    logic rx_meta_q; // first stage, read only by second
    logic rx_s_q;    // synchronised receive level
    // two flops before any use of the pin
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_meta_q <= upm_pkg::LINE_IDLE;
            rx_s_q <= upm_pkg::LINE_IDLE;
        end
        else
        begin
            rx_meta_q <= rx_pin;
            rx_s_q <= rx_meta_q;
        end
    end

    // -----------------------------------------------------------------
    // parity units
    // -----------------------------------------------------------------
    upm_par_if tx_par ();     // parity of outgoing word
    upm_par_if rx_par ();     // parity of incoming word
    logic [8:0] rx_sh_q;      // receive shift word
    assign tx_par.data = tx_data;
    assign tx_par.nine_bit = length_select;
    assign tx_par.odd = parity_select;
    assign rx_par.data = rx_sh_q;
    assign rx_par.nine_bit = length_select;
    assign rx_par.odd = parity_select;
    upm_parity u_tx_parity
    (
        .p (tx_par.calc)
    );
    upm_parity u_rx_parity
    (
        .p (rx_par.calc)
    );

    // -----------------------------------------------------------------
    // outgoing word build
    // -----------------------------------------------------------------
    logic [8:0] tx_word; // word as it goes on the line
    // parity takes the place of the top data bit
    always_comb
    begin
        tx_word = tx_data;
        if (!length_select)
        begin
            tx_word[8] = 1'b0; // unused in short frames
        end
        if (parity_enable)
        begin
            tx_word[last_idx] = tx_par.par;
        end
    end

    // -----------------------------------------------------------------
    // transmitter
    // -----------------------------------------------------------------
    upm_pkg::upm_tx_state_type tx_st_q; // transmit state
    logic [15:0] tx_cnt_q;     // cycle within bit
    logic [3:0] tx_bit_q;      // data bit index
    logic [8:0] tx_sh_q;       // transmit shift word
    logic tx_out_q;            // line level
    logic tx_bit_end;          // last cycle of a bit
    assign tx_bit_end = (tx_cnt_q == end_point);
    // takes a word only when idle and enabled
    assign tx_ready = (tx_st_q == upm_pkg::TX_IDLE) & transmitter_enable;
    // start, data, stop sequence, lsb first
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_st_q <= upm_pkg::TX_IDLE;
            tx_cnt_q <= upm_pkg::CNT_RST;
            tx_bit_q <= 4'h0;
            tx_sh_q <= upm_pkg::DATA_RST;
            tx_out_q <= upm_pkg::LINE_IDLE;
        end
        else
        begin
            tx_cnt_q <= tx_bit_end ? upm_pkg::CNT_RST : tx_cnt_q + 16'h0001;
            unique case (tx_st_q)
                upm_pkg::TX_IDLE:
                begin
                    // new frame opens with the start bit
                    tx_cnt_q <= upm_pkg::CNT_RST;
                    if (tx_valid && tx_ready)
                    begin
                        tx_st_q <= upm_pkg::TX_START;
                        tx_sh_q <= tx_word;
                        tx_out_q <= 1'b0;
                    end
                end
                upm_pkg::TX_START:
                begin
                    // first data bit follows
                    if (tx_bit_end)
                    begin
                        tx_st_q <= upm_pkg::TX_DATA;
                        tx_bit_q <= 4'h0;
                        tx_out_q <= tx_sh_q[0];
                    end
                end
                upm_pkg::TX_DATA:
                begin
                    // shift out until the last data bit
                    if (tx_bit_end)
                    begin
                        if (tx_bit_q == last_idx)
                        begin
                            tx_st_q <= upm_pkg::TX_STOP;
                            tx_out_q <= upm_pkg::LINE_IDLE;
                        end
                        else
                        begin
                            tx_bit_q <= tx_bit_q + 4'h1;
                            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                            tx_out_q <= tx_sh_q[1];
                        end
                    end
                end
                upm_pkg::TX_STOP:
                begin
                    // one stop bit then back to rest
                    if (tx_bit_end)
                    begin
                        tx_st_q <= upm_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // synchronous master clock
    // -----------------------------------------------------------------
    logic ck_q;         // clock pin level
    logic ck_active;    // pulse allowed this bit
    logic second_half;  // count in second half of bit
    assign second_half = (tx_cnt_q >= half_point);
    // only data bits, last one on request
    assign ck_active = sync_mode & (tx_st_q == upm_pkg::TX_DATA)
        & ((tx_bit_q != last_idx) | last_bit_clock);
    // phase 0 toggles at mid bit, phase 1 at bit start
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ck_q <= 1'b0;
        end
        else if (ck_active)
        begin
            ck_q <= clock_polarity ^ second_half ^ clock_phase;
        end
        else
        begin
            ck_q <= clock_polarity;
        end
    end
    assign sync_clock_pin_out = ck_q;
    // clock pin never an input, floats when both disabled
    assign sync_clock_pin_oe_n = ~(any_en & sync_mode);
    assign tx_pin_out = tx_out_q;
    assign tx_pin_oe_n = ~any_en;

    // -----------------------------------------------------------------
    // receiver
    // -----------------------------------------------------------------
    upm_pkg::upm_rx_state_type rx_st_q; // async receive state
    logic [15:0] rx_cnt_q;  // cycle within bit
    logic [3:0] rx_bit_q;   // data bit index
    logic rx_done_q;        // one cycle: frame complete
    logic rx_bit_end;       // sample point reached
    logic sync_capture;     // sync sample moment
    assign rx_bit_end = (rx_cnt_q == end_point);
    // phase 0 samples at mid bit, phase 1 at bit end
    assign sync_capture = (tx_st_q == upm_pkg::TX_DATA)
        & (clock_phase ? tx_bit_end : (tx_cnt_q == half_point));
    // async frames by start edge, sync frames by own clock
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_st_q <= upm_pkg::RX_IDLE;
            rx_cnt_q <= upm_pkg::CNT_RST;
            rx_bit_q <= 4'h0;
            rx_sh_q <= upm_pkg::DATA_RST;
            rx_done_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            rx_cnt_q <= rx_bit_end ? upm_pkg::CNT_RST : rx_cnt_q + 16'h0001;
            if (!receiver_enable)
            begin
                rx_st_q <= upm_pkg::RX_IDLE;
                rx_cnt_q <= upm_pkg::CNT_RST;
            end
            else if (sync_mode)
            begin
                // one sample per bit, no oversampling
                rx_st_q <= upm_pkg::RX_IDLE;
                if (sync_capture)
                begin
                    rx_sh_q[tx_bit_q] <= rx_s_q;
                end
                if ((tx_st_q == upm_pkg::TX_STOP) && tx_bit_end)
                begin
                    rx_done_q <= 1'b1;
                end
            end
            else
            begin
                unique case (rx_st_q)
                    upm_pkg::RX_IDLE:
                    begin
                        // low line starts a frame
                        rx_cnt_q <= upm_pkg::CNT_RST;
                        if (!rx_s_q)
                        begin
                            rx_st_q <= upm_pkg::RX_START;
                        end
                    end
                    upm_pkg::RX_START:
                    begin
                        // confirm start at mid bit
                        if (rx_cnt_q == half_point)
                        begin
                            rx_cnt_q <= upm_pkg::CNT_RST;
                            rx_bit_q <= 4'h0;
                            rx_st_q <= rx_s_q ? upm_pkg::RX_IDLE : upm_pkg::RX_DATA;
                            rx_sh_q <= upm_pkg::DATA_RST;
                        end
                    end
                    upm_pkg::RX_DATA:
                    begin
                        // one sample per data bit
                        if (rx_bit_end)
                        begin
                            rx_sh_q[rx_bit_q] <= rx_s_q;
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == last_idx)
                            begin
                                rx_st_q <= upm_pkg::RX_STOP;
                            end
                        end
                    end
                    upm_pkg::RX_STOP:
                    begin
                        // frame ends at stop bit sample
                        if (rx_bit_end)
                        begin
                            rx_st_q <= upm_pkg::RX_IDLE;
                            rx_done_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // idle frame detection
    // -----------------------------------------------------------------
    logic [15:0] idle_cnt_q;  // cycle within idle bit
    logic [3:0] idle_bits_q;  // whole idle bits seen
    logic idle_det;           // a full idle frame seen
    assign idle_det = (idle_cnt_q == end_point) & (idle_bits_q == nbits + upm_pkg::FRAME_EXTRA - 4'h1);
    // counts high bit times after a frame, once per gap
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_cnt_q <= upm_pkg::CNT_RST;
            idle_bits_q <= 4'h0;
        end
        else if (!rx_s_q || !receiver_enable || sync_mode)
        begin
            idle_cnt_q <= upm_pkg::CNT_RST;
            idle_bits_q <= 4'h0;
        end
        else if (idle_bits_q < nbits + upm_pkg::FRAME_EXTRA)
        begin
            idle_cnt_q <= (idle_cnt_q == end_point) ? upm_pkg::CNT_RST : idle_cnt_q + 16'h0001;
            if (idle_cnt_q == end_point)
            begin
                idle_bits_q <= idle_bits_q + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // received word classification
    // -----------------------------------------------------------------
    logic par_bad;     // received parity wrong
    logic is_addr;     // address mark set
    logic addr_hit;    // address matches node
    logic deliver;     // word goes to buffer
    logic go_mute;     // hardware enters mute
    logic wake;        // hardware leaves mute
    assign par_bad = parity_enable & (rx_par.par != rx_sh_q[last_idx]);
    assign is_addr = wake_select & rx_sh_q[mark_idx];
    assign addr_hit = (rx_sh_q[3:0] == node_address);
    // address frames decide mute in address mode
    assign go_mute = rx_done_q & is_addr & ~addr_hit;
    assign wake = (rx_done_q & is_addr & addr_hit)
        | (idle_det & ~wake_select);
    // muted frames leave no trace, matching address is kept
    assign deliver = rx_done_q & ~go_mute & (~receiver_mute | wake);

    // -----------------------------------------------------------------
    // mute bit
    // -----------------------------------------------------------------
    logic mute_q; // mute state
    // software write only with empty buffer, hardware wins
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mute_q <= upm_pkg::MUTE_RST;
        end
        else if (go_mute)
        begin
            mute_q <= 1'b1;
        end
        else if (wake && mute_q)
        begin
            mute_q <= 1'b0;
        end
        else if (mute_write && !rx_not_empty)
        begin
            mute_q <= mute_write_value;
        end
    end
    assign receiver_mute = mute_q;

    // -----------------------------------------------------------------
    // receive buffer and status
    // -----------------------------------------------------------------
    logic [8:0] rx_data_q; // buffered word
    logic rx_not_empty_q;          // buffer full
    logic pe_q;            // sticky parity failure
    // a new word wins over a read in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_data_q <= upm_pkg::DATA_RST;
            rx_not_empty_q <= 1'b0;
        end
        else if (deliver)
        begin
            rx_data_q <= length_select ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
            rx_not_empty_q <= 1'b1;
        end
        else if (rx_read)
        begin
            rx_not_empty_q <= 1'b0;
        end
    end
    // parity flag set wins over clear
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pe_q <= 1'b0;
        end
        else if (deliver && par_bad)
        begin
            pe_q <= 1'b1;
        end
        else if (parity_clear)
        begin
            pe_q <= 1'b0;
        end
    end
    assign rx_data = rx_data_q;
    assign rx_not_empty = rx_not_empty_q;
    assign parity_error_flag = pe_q;
    // no receive interrupt while muted
    assign parity_irq = pe_q & parity_irq_enable & ~mute_q;
endmodule // upm_top
`default_nettype wire

// ### dv/upm_peer.sv
// far-side serial transmitter model driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module upm_peer
(
    input wire logic clk_sys, // system clock
    output logic line         // serial line, idles high
);
    initial line = 1'b1;
    // one frame: start low, bits lsb first, stop high, 16 clocks a bit
    task automatic send(input logic [8:0] w, input int n);
        for (int i = 0; i < n + 2; i++)
        begin
            line <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : w[i-1];
            repeat (16) @(posedge clk_sys);
        end
    endtask
endmodule // upm_peer
`default_nettype wire

// ### dv/upm_top_props.sv
// concurrent checks on the top ports
`timescale 1ns/1ps
`default_nettype none
module upm_top_props
(
    input wire logic clk_sys, sys_rst, transmitter_enable, receiver_enable, sync_clock_enable, // controls
    input wire logic lin_enable, wake_select, mute_write, mute_write_value, clock_polarity, // controls
    input wire logic parity_irq_enable, tx_valid, tx_ready, rx_not_empty, parity_error_flag, // handshake
    input wire logic parity_irq, receiver_mute, tx_pin_out, tx_pin_oe_n, sync_clock_pin_out, // outputs
    input wire logic sync_clock_pin_oe_n // clock pin enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_float_pins: assert property (!(transmitter_enable || receiver_enable) |-> tx_pin_oe_n && sync_clock_pin_oe_n)
        else $error("pins driven while disabled");
    chk_clock_drive: assert property ((transmitter_enable || receiver_enable) && sync_clock_enable && !lin_enable
        |-> !sync_clock_pin_oe_n) else $error("clock pin not driven");
    chk_irq_gate: assert property (parity_irq == (parity_error_flag && parity_irq_enable && !receiver_mute))
        else $error("parity interrupt wrong");
    chk_start_bit: assert property (tx_valid && tx_ready |=> !tx_pin_out && !tx_ready)
        else $error("no start bit");
    chk_clock_idle: assert property (tx_ready [*3] |-> sync_clock_pin_out == clock_polarity)
        else $error("clock not idle");
    chk_mute_take: assert property (mute_write && !rx_not_empty && !wake_select
        |=> receiver_mute == $past(mute_write_value)) else $error("mute write lost");
    chk_word_awake: assert property ($rose(rx_not_empty) |-> !receiver_mute)
        else $error("word while mute");
    chk_flag_word: assert property ($rose(parity_error_flag) |-> ##[0:2] rx_not_empty)
        else $error("flag without word");
endmodule // upm_top_props
bind upm_top upm_top_props u_props (.*);
`default_nettype wire

// ### dv/upm_top_test.sv
// self-checking bench for the parity, mute and sync clock top
`timescale 1ns/1ps
`default_nettype none
module upm_top_test;
    logic clk_sys = 1'b0, sys_rst = 1'b1, transmitter_enable, receiver_enable, sync_clock_enable, lin_enable;
    logic length_select, parity_enable, parity_select, parity_irq_enable, parity_clear, wake_select, mute_write;
    logic mute_write_value, last_bit_clock, clock_polarity, clock_phase, tx_valid, rx_read;
    logic [15:0] baud_div = 16'h0010; // shortest legal bit
    logic [3:0] node_address = 4'h5; // own node
    logic [8:0] tx_data = 9'h000;
    wire logic tx_ready, rx_not_empty, parity_error_flag, parity_irq, receiver_mute, rx_pin;
    wire logic tx_pin_out, tx_pin_oe_n, sync_clock_pin_out, sync_clock_pin_oe_n;
    wire logic [8:0] rx_data;
    int fail_count = 0, comparisons = 0;
    always #20 clk_sys = ~clk_sys;
    upm_top uut (.*);
    upm_peer peer (.clk_sys, .line(rx_pin));
    task automatic report_and_stop;
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // bounded wait: 0 word present, 1 transmitter ready, 2 awake
    task automatic await(input int s);
        int k;
        for (k = 0; k < 400 && !(s == 0 ? rx_not_empty === 1'b1 : s == 1 ? tx_ready === 1'b1 : receiver_mute === 1'b0); k++)
            cyc(1);
        if (k == 400)
        begin
            fail_count++;
            report_and_stop();
        end
        cyc(1);
    endtask
    task automatic pulse(input logic mute);
        {mute_write, mute_write_value, rx_read, parity_clear} <= {mute, mute, !mute, !mute};
        cyc(1);
        {mute_write, rx_read, parity_clear} <= 3'b000;
        cyc(1);
    endtask
    // sends a word, samples bits mid-bit, counts clock pulses
    task automatic tx_word(input logic [8:0] w, output logic [8:0] got, output int pulses);
        int n;
        logic prev;
        n = length_select ? 9 : 8;
        got = 9'h000;
        pulses = 0;
        await(1);
        {tx_data, tx_valid} <= {w, 1'b1};
        cyc(1);
        tx_valid <= 1'b0;
        prev = clock_polarity;
        for (int k = 1; k <= (n + 2) * 16; k++)
        begin
            cyc(1);
            #1;
            if (k % 16 == 9 && k > 16 && k < (n + 1) * 16)
                got[k / 16 - 1] = tx_pin_out;
            if (prev === clock_polarity && sync_clock_pin_out !== prev)
                pulses++;
            prev = sync_clock_pin_out;
        end
    endtask
    task automatic t_format;
        logic [8:0] got, exp;
        int p, n;
        for (int c = 0; c < 8; c++)
        begin
            {length_select, parity_enable, parity_select} <= c[2:0];
            cyc(1);
            n = length_select ? 9 : 8;
            exp = 9'h1b5 & ~(9'h1ff << n);
            if (parity_enable)
                exp[n-1] = ^(exp & ~(9'h1ff << (n - 1))) ^ parity_select;
            tx_word(9'h1b5, got, p);
            chk(got, exp);
        end
    endtask
    task automatic t_rx_parity;
        {length_select, parity_enable, parity_select} <= 3'b010;
        peer.send(9'h0b5, 8);
        await(0);
        chk(rx_data, 9'h0b5);
        chk({7'h00, parity_error_flag, parity_irq}, 9'h003);
        pulse(1'b0);
        peer.send(9'h035, 8);
        await(0);
        chk({8'h00, parity_error_flag}, 9'h000);
        pulse(1'b0);
    endtask
    task automatic t_address;
        {wake_select, parity_select} <= 2'b11;
        peer.send(9'h083, 8);
        await(0);
        chk({8'h00, receiver_mute}, 9'h000);
        pulse(1'b0);
        peer.send(9'h043, 8);
        peer.send(9'h092, 8);
        cyc(20);
        chk({7'h00, receiver_mute, rx_not_empty}, 9'h002);
        peer.send(9'h045, 8);
        await(0);
        chk({receiver_mute, rx_data[7:0]}, 9'h045);
    endtask
    task automatic t_idle;
        wake_select <= 1'b0;
        pulse(1'b1);
        chk({8'h00, receiver_mute}, 9'h000);
        pulse(1'b0);
        pulse(1'b1);
        chk({8'h00, receiver_mute}, 9'h001);
        peer.send(9'h080, 8);
        cyc(4);
        chk({7'h00, receiver_mute, rx_not_empty}, 9'h002);
        await(2);
    endtask
    task automatic t_sync;
        logic [8:0] got;
        int p;
        {length_select, parity_enable} <= 2'b00;
        for (int c = 0; c < 8; c++)
        begin
            {transmitter_enable, receiver_enable, sync_clock_enable} <= 3'b001;
            cyc(2);
            chk({7'h00, tx_pin_oe_n, sync_clock_pin_oe_n}, 9'h003);
            {clock_phase, last_bit_clock, clock_polarity} <= c[2:0];
            cyc(1);
            {transmitter_enable, receiver_enable} <= 2'b11;
            cyc(3);
            chk({8'h00, sync_clock_pin_out}, {8'h00, c[0]});
            tx_word(9'h0a5, got, p);
            chk(p[8:0], 9'd7 + c[1]);
            cyc(2);
            chk(rx_data, 9'h0ff);
        end
        {lin_enable, sync_clock_enable} <= 2'b10;
        cyc(2);
        chk(sync_clock_pin_oe_n, 9'h001);
    endtask
    initial
    begin
        {transmitter_enable, receiver_enable, sync_clock_enable, lin_enable, length_select, parity_enable} = '0;
        {parity_select, parity_clear, wake_select, mute_write, mute_write_value, last_bit_clock} = '0;
        {clock_polarity, clock_phase, tx_valid, rx_read, parity_irq_enable} = 5'b00001;
        cyc(12);
        {sys_rst, transmitter_enable, receiver_enable} <= 3'b011;
        t_format();
        t_rx_parity();
        t_address();
        t_idle();
        t_sync();
        report_and_stop();
    end
endmodule // upm_top_test
`default_nettype wire
